// File: design/pdam_pkg.sv
// Purpose: Shared constants and types for the program/data address map
// Assumes: 16-bit core, 24-bit program space, 8 KB data RAM
// Notes: Every address, width and step used by the map is named here

package pdam_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int PROG_AW = 24;
  localparam int PC_W = 23;
  localparam int DW = 16;
  localparam int BW = 8;
  localparam int PAGE_W = 8;
  localparam int VEC_NUM_W = 7;
  localparam int RAM_AW = 12;

  // ****************************************************************
  // Program space
  // ****************************************************************
  localparam logic [PC_W-1:0] PC_RESET = 23'h000000;
  localparam logic [PC_W-1:0] PC_STEP = 23'h000002;
  localparam logic [PC_W-1:0] VEC_REGION_END = 23'h000200;
  localparam logic [PROG_AW-1:0] IVT_BASE = 24'h000004;
  localparam logic [PROG_AW-1:0] AIVT_BASE = 24'h000100;
  localparam int PROG_UPPER_BIT = 23;
  localparam int PAGE_CFG_BIT = 7;
  localparam logic [2:0] PSTRB_NONE = 3'h0;
  localparam logic [2:0] PSTRB_LOWER = 3'h3;
  localparam logic [2:0] PSTRB_UPPER = 3'h4;

  // ****************************************************************
  // Data space
  // ****************************************************************
  localparam int EA_WINDOW_BIT = 15;
  localparam logic [DW-1:0] RAM_LIMIT = 16'h2000;
  localparam logic [DW-1:0] BYTE_INC = 16'h0001;
  localparam logic [DW-1:0] WORD_INC = 16'h0002;
  localparam logic [BW-1:0] BYTE_ZERO = 8'h00;
  localparam logic [DW-1:0] WORD_ZERO = 16'h0000;
  localparam logic [1:0] LANE_NONE = 2'h0;
  localparam logic [1:0] LANE_LO = 2'h1;
  localparam logic [1:0] LANE_HI = 2'h2;
  localparam logic [1:0] LANE_BOTH = 2'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [1:0] {
    WOP_WORD = 2'h0,
    WOP_BYTE = 2'h1,
    WOP_SIGN = 2'h2,
    WOP_ZERO = 2'h3
  } pdam_wop_t;

  typedef enum logic [1:0] {
    ERR_IDLE = 2'h1,
    ERR_PEND = 2'h2
  } pdam_err_t;

endpackage

// File: design/pdam_ram.sv
// Purpose: Data RAM with one read port and one byte-laned write port
// Assumes: Read is combinational, write lands on the clock edge
// Notes: A read of the word being written returns the old contents

module pdam_ram #(
  parameter int AW = pdam_pkg::RAM_AW,
  parameter int DW = pdam_pkg::DW
) (
  // Clock
  input wire logic i_clk,
  // Write port
  input wire logic [AW-1:0] i_wr_addr,
  input wire logic [1:0] i_wr_be,
  input wire logic [DW-1:0] i_wr_data,
  // Read port
  input wire logic [AW-1:0] i_rd_addr,
  output logic [DW-1:0] o_rd_data
);

  localparam int LW = DW / 2;

  logic [DW-1:0] mem [0:(1<<AW)-1];

  // ****************************************************************
  // Lane writes
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    for (int l = 0; l < 2; l++) begin
      if (i_wr_be[l]) begin
        mem[i_wr_addr][l*LW +: LW] <= i_wr_data[l*LW +: LW];
      end
    end
  end

  assign o_rd_data = mem[i_rd_addr];

endmodule

// File: design/pdam_top.sv
// Purpose: Program and data address map of a 16-bit core
// Assumes: Single core clock, synchronous active-high reset
// Notes: Program port, O_TBL_BUSY and O_IN_VECTORS are combinational; other results are registered
module pdam_top (
  // Clock and reset
  input wire logic I_MCLK,
  input wire logic I_RESET,
  // Program counter
  input wire logic I_PC_LOAD,
  input wire logic I_PC_STEP,
  input wire logic I_PC_BACK,
  input wire logic [pdam_pkg::PC_W-1:0] I_PC_TARGET,
  output logic [pdam_pkg::PC_W-1:0] O_PC,
  output logic O_IN_VECTORS,
  // Vector lookup
  input wire logic I_VEC_REQ,
  input wire logic I_VEC_ALT,
  input wire logic [pdam_pkg::VEC_NUM_W-1:0] I_VEC_NUM,
  output logic [pdam_pkg::PROG_AW-1:0] O_VEC_ADDR,
  output logic O_VEC_VALID,
  // Program memory port
  output logic [pdam_pkg::PROG_AW-1:0] O_PMEM_ADDR,
  output logic O_PMEM_WE,
  output logic [2:0] O_PMEM_WSTRB,
  output logic [pdam_pkg::PROG_AW-1:0] O_PMEM_WDATA,
  input wire logic [pdam_pkg::PROG_AW-1:0] I_PMEM_RDATA,
  // Table operations
  input wire logic I_TBL_RD,
  input wire logic I_TBL_WR,
  input wire logic [pdam_pkg::PAGE_W-1:0] I_TBL_PAGE,
  input wire logic [pdam_pkg::DW-1:0] I_TBL_OFFSET,
  input wire logic [pdam_pkg::DW-1:0] I_TBL_WDATA,
  output logic O_TBL_BUSY,
  output logic [pdam_pkg::DW-1:0] O_TBL_RDATA,
  output logic O_TBL_VALID,
  // Data read generator
  input wire logic I_RD_REQ,
  input wire logic [pdam_pkg::DW-1:0] I_RD_EA,
  input wire logic I_RD_BYTE,
  input wire logic I_PSV_EN,
  input wire logic [pdam_pkg::PAGE_W-1:0] I_PSV_PAGE,
  output logic [pdam_pkg::DW-1:0] O_RD_DATA,
  output logic O_RD_VALID,
  // Data write generator
  input wire logic I_WR_REQ,
  input wire logic [pdam_pkg::DW-1:0] I_WR_EA,
  input wire logic I_WR_BYTE,
  input wire logic [pdam_pkg::DW-1:0] I_WR_DATA,
  // Pointer update
  input wire logic I_PTR_REQ,
  input wire logic [pdam_pkg::DW-1:0] I_PTR,
  input wire logic I_PTR_BYTE,
  output logic [pdam_pkg::DW-1:0] O_PTR_NEXT,
  output logic O_PTR_VALID,
  // Working register load
  input wire logic I_WREG_REQ,
  input wire logic [1:0] I_WREG_OP,
  input wire logic [pdam_pkg::DW-1:0] I_WREG_OLD,
  input wire logic [pdam_pkg::DW-1:0] I_WREG_SRC,
  output logic [pdam_pkg::DW-1:0] O_WREG_NEW,
  output logic O_WREG_VALID,
  // Address error
  input wire logic I_INSN_DONE,
  output logic O_ADDR_ERR_TRAP,
  output logic O_ADDR_ERR_WRITE
);
  localparam int AW = pdam_pkg::RAM_AW;
  localparam int BW = pdam_pkg::BW;
  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic in_ram(input logic [pdam_pkg::DW-1:0] ea);
    in_ram = !ea[pdam_pkg::EA_WINDOW_BIT] && (ea < pdam_pkg::RAM_LIMIT);
  endfunction
  function automatic logic [pdam_pkg::DW-1:0] lane_pick(
    input logic [pdam_pkg::DW-1:0] word, input logic hi);
    lane_pick = {pdam_pkg::BYTE_ZERO, hi ? word[2*BW-1:BW] : word[BW-1:0]};
  endfunction
  function automatic logic [pdam_pkg::DW-1:0] ea_step(
    input logic [pdam_pkg::DW-1:0] ptr, input logic is_byte);
    ea_step = ptr + (is_byte ? pdam_pkg::BYTE_INC : pdam_pkg::WORD_INC);
  endfunction
  // ****************************************************************
  // Program counter
  // ****************************************************************
  logic [pdam_pkg::PC_W-1:0] pc_q, pc_d;
  always_comb begin
    pc_d = pc_q;
    if (I_PC_LOAD) begin
      pc_d = {I_PC_TARGET[pdam_pkg::PC_W-1:1], 1'h0};
    end else if (I_PC_STEP) begin
      pc_d = I_PC_BACK ? pc_q - pdam_pkg::PC_STEP : pc_q + pdam_pkg::PC_STEP;
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      pc_q <= pdam_pkg::PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end
  assign O_PC = pc_q;
  assign O_IN_VECTORS = pc_q < pdam_pkg::VEC_REGION_END;
  // ****************************************************************
  // Program port
  // ****************************************************************
  logic psv_act, tbl_act, tbl_take, rd_mis, wr_mis;
  logic [pdam_pkg::PROG_AW-1:0] psv_addr, tbl_addr, fetch_addr;
  assign psv_act = I_RD_REQ && I_RD_EA[pdam_pkg::EA_WINDOW_BIT] && I_PSV_EN;
  assign tbl_act = I_TBL_RD || I_TBL_WR;
  assign tbl_take = tbl_act && !psv_act;
  assign O_TBL_BUSY = tbl_act && psv_act;
  assign fetch_addr = {1'h0, pc_q};
  assign psv_addr = {1'h0, I_PSV_PAGE, I_RD_EA[pdam_pkg::EA_WINDOW_BIT-1:1], 1'h0};
  // page bit 7 reaches configuration space
  assign tbl_addr = {I_TBL_PAGE, I_TBL_OFFSET[pdam_pkg::DW-1:1], I_TBL_OFFSET[0]};
  // only table ops leave the lower half
  assign O_PMEM_ADDR = psv_act ? psv_addr : tbl_act ? tbl_addr : fetch_addr;
  // even offset lower word, odd offset upper byte
  assign O_PMEM_WE = I_TBL_WR && tbl_take;
  assign O_PMEM_WSTRB = !O_PMEM_WE ? pdam_pkg::PSTRB_NONE :
                        I_TBL_OFFSET[0] ? pdam_pkg::PSTRB_UPPER : pdam_pkg::PSTRB_LOWER;
  assign O_PMEM_WDATA = {I_TBL_WDATA[BW-1:0], I_TBL_WDATA};
  // ****************************************************************
  // Data RAM
  // ****************************************************************
  logic [1:0] ram_be;
  logic [pdam_pkg::DW-1:0] ram_wdata, ram_rdata;
  assign rd_mis = I_RD_REQ && !I_RD_BYTE && I_RD_EA[0];
  assign wr_mis = I_WR_REQ && !I_WR_BYTE && I_WR_EA[0];
  always_comb begin
    ram_be = pdam_pkg::LANE_NONE;
    ram_wdata = I_WR_DATA;
    if (I_WR_REQ && in_ram(I_WR_EA) && !wr_mis) begin
      if (!I_WR_BYTE) begin
        ram_be = pdam_pkg::LANE_BOTH;
      end else begin
        // odd address is the high lane
        ram_be = I_WR_EA[0] ? pdam_pkg::LANE_HI : pdam_pkg::LANE_LO;
        ram_wdata = {I_WR_DATA[BW-1:0], I_WR_DATA[BW-1:0]};
      end
    end
  end
  pdam_ram #(
    .AW(AW),
    .DW(pdam_pkg::DW)
  ) u_ram (
    .i_clk(I_MCLK),
    .i_wr_addr(I_WR_EA[AW:1]),
    .i_wr_be(ram_be),
    .i_wr_data(ram_wdata),
    .i_rd_addr(I_RD_EA[AW:1]),
    .o_rd_data(ram_rdata)
  );
  // ****************************************************************
  // Results
  // ****************************************************************
  logic [pdam_pkg::DW-1:0] rd_q, rd_d, tbl_q, tbl_d, ptr_q, ptr_d, wreg_q, wreg_d;
  logic [pdam_pkg::PROG_AW-1:0] vec_q, vec_d;
  logic rdv_q, tblv_q, ptrv_q, wregv_q, vecv_q;
  logic [pdam_pkg::DW-1:0] rd_word, tbl_word;
  always_comb begin
    rd_word = in_ram(I_RD_EA) ? ram_rdata :
              psv_act ? I_PMEM_RDATA[pdam_pkg::DW-1:0] : pdam_pkg::WORD_ZERO;
    rd_d = !I_RD_REQ ? rd_q : I_RD_BYTE ? lane_pick(rd_word, I_RD_EA[0]) : rd_word;
    // upper word has no top byte
    tbl_word = I_TBL_OFFSET[0] ?
               {pdam_pkg::BYTE_ZERO, I_PMEM_RDATA[pdam_pkg::PROG_AW-1:pdam_pkg::DW]} :
               I_PMEM_RDATA[pdam_pkg::DW-1:0];
    tbl_d = I_TBL_RD && tbl_take ? tbl_word : tbl_q;
    ptr_d = I_PTR_REQ ? ea_step(I_PTR, I_PTR_BYTE) : ptr_q;
    vec_d = !I_VEC_REQ ? vec_q : (I_VEC_ALT ? pdam_pkg::AIVT_BASE : pdam_pkg::IVT_BASE) +
            {{(pdam_pkg::PROG_AW-pdam_pkg::VEC_NUM_W-1){1'h0}}, I_VEC_NUM, 1'h0};
    wreg_d = wreg_q;
    if (I_WREG_REQ) begin
      case (pdam_pkg::pdam_wop_t'(I_WREG_OP))
        pdam_pkg::WOP_WORD: wreg_d = I_WREG_SRC;
        pdam_pkg::WOP_BYTE: wreg_d = {I_WREG_OLD[2*BW-1:BW], I_WREG_SRC[BW-1:0]};
        pdam_pkg::WOP_SIGN: wreg_d = {{BW{I_WREG_OLD[BW-1]}}, I_WREG_OLD[BW-1:0]};
        pdam_pkg::WOP_ZERO: wreg_d = {pdam_pkg::BYTE_ZERO, I_WREG_OLD[BW-1:0]};
        default: wreg_d = wreg_q;
      endcase
    end
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      rd_q <= pdam_pkg::WORD_ZERO;
      tbl_q <= pdam_pkg::WORD_ZERO;
      ptr_q <= pdam_pkg::WORD_ZERO;
      wreg_q <= pdam_pkg::WORD_ZERO;
      vec_q <= pdam_pkg::IVT_BASE;
      rdv_q <= 1'h0;
      tblv_q <= 1'h0;
      ptrv_q <= 1'h0;
      wregv_q <= 1'h0;
      vecv_q <= 1'h0;
    end else begin
      rd_q <= rd_d;
      tbl_q <= tbl_d;
      ptr_q <= ptr_d;
      wreg_q <= wreg_d;
      vec_q <= vec_d;
      rdv_q <= I_RD_REQ;
      tblv_q <= I_TBL_RD && tbl_take;
      ptrv_q <= I_PTR_REQ;
      wregv_q <= I_WREG_REQ;
      vecv_q <= I_VEC_REQ;
    end
  end
  assign O_RD_DATA = rd_q;
  assign O_RD_VALID = rdv_q;
  assign O_TBL_RDATA = tbl_q;
  assign O_TBL_VALID = tblv_q;
  assign O_PTR_NEXT = ptr_q;
  assign O_PTR_VALID = ptrv_q;
  assign O_WREG_NEW = wreg_q;
  assign O_WREG_VALID = wregv_q;
  assign O_VEC_ADDR = vec_q;
  assign O_VEC_VALID = vecv_q;
  // ****************************************************************
  // Address error trap
  // ****************************************************************
  pdam_pkg::pdam_err_t err_q, err_d;
  logic trap_q, trap_d, wflag_q, wflag_d;
  always_comb begin
    err_d = err_q;
    trap_d = 1'h0;
    wflag_d = wflag_q;
    case (err_q)
      pdam_pkg::ERR_IDLE: begin
        if (rd_mis || wr_mis) begin
          wflag_d = wr_mis;
          trap_d = I_INSN_DONE;
          err_d = I_INSN_DONE ? pdam_pkg::ERR_IDLE : pdam_pkg::ERR_PEND;
        end
      end
      pdam_pkg::ERR_PEND: begin
        wflag_d = wflag_q || wr_mis;
        if (I_INSN_DONE) begin
          trap_d = 1'h1;
          err_d = pdam_pkg::ERR_IDLE;
        end
      end
      default: err_d = pdam_pkg::ERR_IDLE;
    endcase
  end
  always_ff @(posedge I_MCLK) begin
    if (I_RESET) begin
      err_q <= pdam_pkg::ERR_IDLE;
      trap_q <= 1'h0;
      wflag_q <= 1'h0;
    end else begin
      err_q <= err_d;
      trap_q <= trap_d;
      wflag_q <= wflag_d;
    end
  end
  assign O_ADDR_ERR_TRAP = trap_q;
  assign O_ADDR_ERR_WRITE = wflag_q;
  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  pc_reset_a: assert property ($fell(I_RESET) |-> O_PC == pdam_pkg::PC_RESET)
    else $error("pc not zero after reset");
  pc_step_a: assert property (I_PC_STEP && !I_PC_LOAD && !I_PC_BACK |=>
    O_PC == pdam_pkg::PC_W'($past(O_PC) + pdam_pkg::PC_STEP))
    else $error("pc did not advance by two");
  pc_align_a: assert property (!O_PC[0]) else $error("pc misaligned");
  vec_base_a: assert property (I_VEC_REQ && I_VEC_ALT && I_VEC_NUM == 7'h00 |=>
    O_VEC_VALID && O_VEC_ADDR == pdam_pkg::AIVT_BASE)
    else $error("alternate vector base wrong");
  zero_ret_a: assert property (I_RD_REQ && !I_RD_EA[15] && I_RD_EA >= pdam_pkg::RAM_LIMIT
    |=> O_RD_VALID && O_RD_DATA == pdam_pkg::WORD_ZERO)
    else $error("unimplemented read not zero");
  byte_lane_a: assert property (I_RD_REQ && I_RD_BYTE |=> O_RD_DATA[15:8] == 8'h00)
    else $error("byte read high lane not zero");
  wr_drop_a: assert property (wr_mis |-> ram_be == pdam_pkg::LANE_NONE)
    else $error("misaligned write reached ram");
  byte_strobe_a: assert property (I_WR_REQ && I_WR_BYTE |-> ram_be != pdam_pkg::LANE_BOTH)
    else $error("byte write hit both lanes");
  trap_pulse_a: assert property (O_ADDR_ERR_TRAP |=> !O_ADDR_ERR_TRAP)
    else $error("trap longer than one cycle");
  trap_rd_a: assert property (rd_mis && !wr_mis && I_INSN_DONE && err_q == pdam_pkg::ERR_IDLE
    |=> O_ADDR_ERR_TRAP && !O_ADDR_ERR_WRITE)
    else $error("misaligned read trap missing");
  ptr_step_a: assert property (I_PTR_REQ && I_PTR_BYTE |=>
    O_PTR_NEXT == 16'($past(I_PTR) + pdam_pkg::BYTE_INC))
    else $error("byte post-increment wrong");
  byte_load_a: assert property (I_WREG_REQ && I_WREG_OP == pdam_pkg::WOP_BYTE |=>
    O_WREG_NEW[15:8] == $past(I_WREG_OLD[15:8]))
    else $error("byte load touched high byte");
  lower_half_a: assert property (!tbl_act |-> !O_PMEM_ADDR[23])
    else $error("upper half reached without table op");
endmodule

// File: verif/pdam_pmem_model.sv
// Purpose: Program memory seen from the far side of the address map
// Assumes: Read answers in the same cycle, writes land on the clock edge
// Notes: Unwritten words read as zero, like unimplemented program space

module pdam_pmem_model (
  // Clock
  input wire logic i_clk,
  // Program memory port
  input wire logic [23:0] i_addr,
  input wire logic i_we,
  input wire logic [2:0] i_strb,
  input wire logic [23:0] i_wdata,
  output logic [23:0] o_rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [23:0] mem [logic [22:0]];
  int n_wr = 0;

  // one entry per word, either half
  always @(i_addr or n_wr) begin
    o_rdata = mem.exists(i_addr[23:1]) ? mem[i_addr[23:1]] : 24'h000000;
  end

  // lower word and upper byte apart
  always @(posedge i_clk) begin
    logic [23:0] v;
    if (i_we === 1'b1) begin
      v = mem.exists(i_addr[23:1]) ? mem[i_addr[23:1]] : 24'h000000;
      if (i_strb[0]) v[7:0] = i_wdata[7:0];
      if (i_strb[1]) v[15:8] = i_wdata[15:8];
      if (i_strb[2]) v[23:16] = i_wdata[23:16];
      mem[i_addr[23:1]] = v;
      n_wr++;
    end
  end
endmodule

// File: verif/tb.sv
// Purpose: Self-checking bench for the program/data address map
// Assumes: Program memory partner answers in the same cycle
// Notes: One idle cycle separates the requests of the tasks

module tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ****************************************************************
  // Signals and models
  // ****************************************************************
  logic I_MCLK = 0, I_RESET = 1, I_PC_LOAD = 0, I_PC_STEP = 0, I_PC_BACK = 0;
  logic I_VEC_REQ = 0, I_VEC_ALT = 0, I_TBL_RD = 0, I_TBL_WR = 0, I_RD_REQ = 0;
  logic I_RD_BYTE = 0, I_PSV_EN = 0, I_WR_REQ = 0, I_WR_BYTE = 0, I_PTR_REQ = 0;
  logic I_PTR_BYTE = 0, I_WREG_REQ = 0, I_INSN_DONE = 0;
  logic [22:0] I_PC_TARGET = 0;
  logic [6:0] I_VEC_NUM = 0;
  logic [1:0] I_WREG_OP = 0;
  logic [7:0] I_TBL_PAGE = 0, I_PSV_PAGE = 0;
  logic [15:0] I_TBL_OFFSET = 0, I_TBL_WDATA = 0, I_RD_EA = 0, I_WR_EA = 0, I_WR_DATA = 0;
  logic [15:0] I_PTR = 0, I_WREG_OLD = 0, I_WREG_SRC = 0;
  logic [23:0] I_PMEM_RDATA, O_VEC_ADDR, O_PMEM_ADDR, O_PMEM_WDATA;
  logic [22:0] O_PC;
  logic [2:0] O_PMEM_WSTRB;
  logic [15:0] O_TBL_RDATA, O_RD_DATA, O_PTR_NEXT, O_WREG_NEW;
  logic O_IN_VECTORS, O_VEC_VALID, O_PMEM_WE, O_TBL_BUSY, O_TBL_VALID, O_RD_VALID;
  logic O_PTR_VALID, O_WREG_VALID, O_ADDR_ERR_TRAP, O_ADDR_ERR_WRITE;
  int n_mismatch = 0, cmp_count = 0, n_trap = 0;
  logic [15:0] ram [4096];
  logic [23:0] pm [logic [22:0]];
  logic [22:0] pc = 0;

  pdam_top u_dut (
    .I_MCLK, .I_RESET, .I_PC_LOAD, .I_PC_STEP, .I_PC_BACK, .I_PC_TARGET, .O_PC,
    .O_IN_VECTORS, .I_VEC_REQ, .I_VEC_ALT, .I_VEC_NUM, .O_VEC_ADDR, .O_VEC_VALID,
    .O_PMEM_ADDR, .O_PMEM_WE, .O_PMEM_WSTRB, .O_PMEM_WDATA, .I_PMEM_RDATA,
    .I_TBL_RD, .I_TBL_WR, .I_TBL_PAGE, .I_TBL_OFFSET, .I_TBL_WDATA, .O_TBL_BUSY,
    .O_TBL_RDATA, .O_TBL_VALID, .I_RD_REQ, .I_RD_EA, .I_RD_BYTE, .I_PSV_EN,
    .I_PSV_PAGE, .O_RD_DATA, .O_RD_VALID, .I_WR_REQ, .I_WR_EA, .I_WR_BYTE, .I_WR_DATA,
    .I_PTR_REQ, .I_PTR, .I_PTR_BYTE, .O_PTR_NEXT, .O_PTR_VALID, .I_WREG_REQ,
    .I_WREG_OP, .I_WREG_OLD, .I_WREG_SRC, .O_WREG_NEW, .O_WREG_VALID, .I_INSN_DONE,
    .O_ADDR_ERR_TRAP, .O_ADDR_ERR_WRITE
  );

  pdam_pmem_model u_pmem (
    .i_clk(I_MCLK), .i_addr(O_PMEM_ADDR), .i_we(O_PMEM_WE), .i_strb(O_PMEM_WSTRB),
    .i_wdata(O_PMEM_WDATA), .o_rdata(I_PMEM_RDATA)
  );

  always #12.5 I_MCLK = ~I_MCLK;

  always @(posedge I_MCLK) begin
    if (O_ADDR_ERR_TRAP === 1'b1) n_trap++;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tick;
    @(posedge I_MCLK);
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  function automatic logic [23:0] pget(input logic [22:0] k);
    return pm.exists(k) ? pm[k] : 24'h000000;
  endfunction

  task automatic pc_op(input logic ld, st, bk, input logic [22:0] t);
    tick;
    I_PC_LOAD <= ld;
    I_PC_STEP <= st;
    I_PC_BACK <= bk;
    I_PC_TARGET <= t;
    tick;
    I_PC_LOAD <= 0;
    I_PC_STEP <= 0;
    if (ld) pc = {t[22:1], 1'b0};
    else if (st) pc = bk ? pc - 23'h000002 : pc + 23'h000002;
    #1 chk(O_PC, pc);
    chk(O_IN_VECTORS, pc < 23'h000200);
    chk(O_PMEM_ADDR, {1'b0, pc});
  endtask

  task automatic vec(input logic alt, input logic [6:0] num);
    tick;
    I_VEC_REQ <= 1;
    I_VEC_ALT <= alt;
    I_VEC_NUM <= num;
    tick;
    I_VEC_REQ <= 0;
    #1 chk(O_VEC_VALID, 1);
    chk(O_VEC_ADDR, (alt ? 24'h000100 : 24'h000004) + 24'(num) * 2);
  endtask

  task automatic ptr_op(input logic [15:0] p, input logic b);
    tick;
    I_PTR_REQ <= 1;
    I_PTR <= p;
    I_PTR_BYTE <= b;
    tick;
    I_PTR_REQ <= 0;
    #1 chk(O_PTR_VALID, 1);
    chk(O_PTR_NEXT, 16'(p + (b ? 16'h0001 : 16'h0002)));
  endtask

  task automatic wreg(input logic [1:0] op, input logic [15:0] o, s);
    logic [15:0] e;
    tick;
    I_WREG_REQ <= 1;
    I_WREG_OP <= op;
    I_WREG_OLD <= o;
    I_WREG_SRC <= s;
    tick;
    I_WREG_REQ <= 0;
    case (op)
      2'h0: e = s;
      2'h1: e = {o[15:8], s[7:0]};
      2'h2: e = {{8{o[7]}}, o[7:0]};
      default: e = {8'h00, o[7:0]};
    endcase
    #1 chk(O_WREG_VALID, 1);
    chk(O_WREG_NEW, e);
  endtask

  task automatic wr(input logic [15:0] ea, input logic b, input logic [15:0] d);
    tick;
    I_WR_REQ <= 1;
    I_WR_EA <= ea;
    I_WR_BYTE <= b;
    I_WR_DATA <= d;
    tick;
    I_WR_REQ <= 0;
    if (!ea[15] && ea < 16'h2000 && !b && !ea[0]) ram[ea[12:1]] = d;
    if (!ea[15] && ea < 16'h2000 && b && ea[0]) ram[ea[12:1]][15:8] = d[7:0];
    if (!ea[15] && ea < 16'h2000 && b && !ea[0]) ram[ea[12:1]][7:0] = d[7:0];
  endtask

  task automatic rd(input logic [15:0] ea, input logic b, pe, input logic [7:0] pg);
    logic [15:0] w;
    tick;
    I_RD_REQ <= 1;
    I_RD_EA <= ea;
    I_RD_BYTE <= b;
    I_PSV_EN <= pe;
    I_PSV_PAGE <= pg;
    tick;
    I_RD_REQ <= 0;
    w = 16'h0000;
    if (!ea[15] && ea < 16'h2000) w = ram[ea[12:1]];
    if (ea[15] && pe) w = 16'(pget({1'b0, pg, ea[14:1]}));
    if (b) w = ea[0] ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
    #1 chk(O_RD_VALID, 1);
    chk(O_RD_DATA, w);
  endtask

  task automatic tbl(input logic w, input logic [7:0] pg, input logic [15:0] off, d);
    logic [23:0] v;
    tick;
    I_TBL_RD <= !w;
    I_TBL_WR <= w;
    I_TBL_PAGE <= pg;
    I_TBL_OFFSET <= off;
    I_TBL_WDATA <= d;
    tick;
    I_TBL_RD <= 0;
    I_TBL_WR <= 0;
    v = pget({pg, off[15:1]});
    if (w && off[0]) v[23:16] = d[7:0];
    else if (w) v[15:0] = d;
    if (w) pm[{pg, off[15:1]}] = v;
    #1 chk(O_TBL_VALID, !w);
    if (!w) chk(O_TBL_RDATA, off[0] ? {8'h00, v[23:16]} : v[15:0]);
  endtask

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    repeat (20000) tick;
    n_mismatch++;
    wrap_up;
  end

  initial begin
    logic [15:0] aq [8];
    void'($urandom(32'h78f9));
    repeat (3) tick;
    I_RESET <= 0;
    #1 chk(O_PC, 0);
    chk(O_VEC_ADDR, 24'h000004);
    chk(O_PMEM_ADDR, 0);
    pc_op(1, 1, 0, 23'h0001fd);
    pc_op(0, 1, 0, 0);
    pc_op(0, 1, 0, 0);
    pc_op(0, 1, 1, 0);
    pc_op(0, 0, 1, 0);
    repeat (6) pc_op(0, 1, 1'($urandom), 0);
    vec(0, 7'h00);
    vec(1, 7'h00);
    vec(1, 7'h7f);
    repeat (4) vec(1'($urandom), 7'($urandom));
    ptr_op(16'hffff, 1);
    ptr_op(16'hfffe, 0);
    repeat (4) ptr_op(16'($urandom), 1'($urandom));
    for (int i = 0; i < 8; i++) wreg(i[1:0], {8'($urandom), i[2], 7'($urandom)}, 16'($urandom));
    for (int i = 0; i < 8; i++) begin
      aq[i] = (i == 7) ? 16'h1ffe : {3'h0, 12'($urandom), 1'b0};
      wr(aq[i], 0, 16'($urandom));
    end
    wr(aq[0] | 16'h2000, 0, 16'hffff);
    wr(aq[1] | 16'h8000, 0, 16'hffff);
    foreach (aq[i]) begin
      wr(aq[i] | 16'h0001, 1, 16'($urandom));
      rd(aq[i], 0, 0, 0);
      rd(aq[i] | 16'h0001, 1, 0, 0);
      wr(aq[i], 1, 16'($urandom));
      rd(aq[i], 1, 0, 0);
      rd(aq[i], 0, 0, 0);
    end
    rd(16'h2000, 0, 0, 0);
    rd(16'h7fff, 1, 0, 0);
    rd(16'h9000, 0, 0, 8'h01);
    tbl(1, 8'h12, 16'h3456, 16'hbeef);
    tbl(1, 8'h12, 16'h3457, 16'h00a5);
    tbl(0, 8'h12, 16'h3456, 0);
    tbl(0, 8'h12, 16'h3457, 0);
    tbl(1, 8'hf8, 16'h0010, 16'($urandom));
    tbl(0, 8'hf8, 16'h0011, 0);
    rd(16'hb456, 0, 1, 8'h24);
    rd(16'hb457, 1, 1, 8'h24);
    rd(16'hb456, 0, 0, 8'h24);
    // Table write refused while the window read holds the port
    tick;
    I_RD_REQ <= 1;
    I_RD_EA <= 16'hb456;
    I_RD_BYTE <= 0;
    I_PSV_EN <= 1;
    I_TBL_WR <= 1;
    I_TBL_OFFSET <= 16'h3456;
    I_TBL_WDATA <= 16'h0000;
    #1 chk(O_TBL_BUSY, 1);
    tick;
    I_RD_REQ <= 0;
    I_TBL_WR <= 0;
    #1 chk(O_RD_DATA, 16'hbeef);
    tbl(0, 8'h12, 16'h3456, 0);
    // Misaligned word write, instruction ends at once
    tick;
    I_WR_REQ <= 1;
    I_WR_EA <= aq[0] | 16'h0001;
    I_WR_BYTE <= 0;
    I_INSN_DONE <= 1;
    tick;
    I_WR_REQ <= 0;
    I_INSN_DONE <= 0;
    #1 chk(O_ADDR_ERR_TRAP, 1);
    chk(O_ADDR_ERR_WRITE, 1);
    rd(aq[0], 0, 0, 0);
    // Misaligned word read, instruction ends later
    rd(aq[1] | 16'h0001, 0, 0, 0);
    tick;
    I_INSN_DONE <= 1;
    #1 chk(O_ADDR_ERR_TRAP, 0);
    tick;
    I_INSN_DONE <= 0;
    #1 chk(O_ADDR_ERR_TRAP, 1);
    chk(O_ADDR_ERR_WRITE, 0);
    // Misaligned word read, instruction ends at once
    tick;
    I_RD_REQ <= 1;
    I_RD_EA <= aq[2] | 16'h0001;
    I_RD_BYTE <= 0;
    I_INSN_DONE <= 1;
    tick;
    I_RD_REQ <= 0;
    I_INSN_DONE <= 0;
    #1 chk(O_ADDR_ERR_TRAP, 1);
    chk(O_ADDR_ERR_WRITE, 0);
    chk(O_RD_DATA, ram[aq[2][12:1]]);
    tick;
    #1 chk(n_trap, 3);
    wrap_up;
  end
endmodule
